// ===== design/pefs_energy_watch.sv
// line energy presence with a no-energy timeout
`timescale 1ns/1ps
module pefs_energy_watch #(
  parameter int TIMEOUT_CYCLES = pefs_pkg::ENERGY_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // synchronised energy indication
  input wire logic energy_seen,
  // status
  output logic line_energy_present
);

  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);

  logic [CW-1:0] quiet_cnt;

  if (TIMEOUT_CYCLES < 2) begin : g_bad_timeout
    $error("pefs_energy_watch: TIMEOUT_CYCLES must be at least 2");
  end

  // quiet time counter restarts on every sign of energy
  always_ff @(posedge clk_sys) begin
    if (sys_rst || energy_seen) begin
      quiet_cnt <= '0;
    end else if (quiet_cnt != CW'(TIMEOUT_CYCLES - 1)) begin
      quiet_cnt <= quiet_cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      line_energy_present <= 1'b1;
    end else if (energy_seen) begin
      line_energy_present <= 1'b1;
    end else if (quiet_cnt == CW'(TIMEOUT_CYCLES - 1)) begin
      line_energy_present <= 1'b0;
    end
  end

  energy_fall_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !energy_seen && quiet_cnt == CW'(TIMEOUT_CYCLES - 1) |=> !line_energy_present)
    else $error("energy status did not fall at timeout");

endmodule : pefs_energy_watch

// ===== design/pefs_mgmt_slave.sv
// management serial frame receiver and read data driver
`timescale 1ns/1ps
module pefs_mgmt_slave (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // synchronised management line
  input wire logic mdc_rise,
  input wire logic mdio_bit,
  input wire logic [4:0] phy_addr,
  // register side
  input wire logic [15:0] rd_data,
  output pefs_pkg::pefs_mgmt_req_t req,
  // data pin drive
  output logic mdio_out,
  output logic mdio_oe_n
);

  typedef enum logic [2:0] {S_PRE, S_START, S_HDR, S_TA, S_RD, S_WR} pefs_mstate_t;

  pefs_mstate_t state;
  logic [5:0] ones;
  logic [3:0] cnt;
  logic [15:0] shift;
  logic is_read;
  logic [11:0] hdr;

  assign hdr = {shift[10:0], mdio_bit};

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= S_PRE;
      ones <= '0;
      cnt <= '0;
      shift <= '0;
      is_read <= 1'b0;
      req <= '0;
      mdio_out <= 1'b1;
      mdio_oe_n <= 1'b1;
    end else begin
      req.rd <= 1'b0;
      req.wr <= 1'b0;
      if (mdc_rise) begin
        case (state)
          S_PRE: begin
            if (mdio_bit) begin
              if (ones != 6'(pefs_pkg::PREAMBLE_ONES)) begin
                ones <= ones + 6'd1;
              end
            end else begin
              state <= (ones == 6'(pefs_pkg::PREAMBLE_ONES)) ? S_START : S_PRE;
              ones <= '0;
            end
          end
          S_START: begin
            state <= mdio_bit ? S_HDR : S_PRE;
            cnt <= '0;
          end
          S_HDR: begin
            shift <= {shift[14:0], mdio_bit};
            cnt <= cnt + 4'd1;
            if (cnt == 4'(pefs_pkg::HDR_BITS - 1)) begin
              cnt <= '0;
              req.reg_addr <= hdr[4:0];
              is_read <= hdr[11:10] == pefs_pkg::OP_READ;
              if (hdr[9:5] == phy_addr && hdr[11:10] == pefs_pkg::OP_READ) begin
                req.rd <= 1'b1;
                state <= S_TA;
              end else if (hdr[9:5] == phy_addr && hdr[11:10] == pefs_pkg::OP_WRITE) begin
                state <= S_TA;
              end else begin
                state <= S_PRE;
              end
            end
          end
          S_TA: begin
            cnt <= cnt + 4'd1;
            if (cnt == 4'd0 && is_read) begin
              mdio_out <= 1'b0;
              mdio_oe_n <= 1'b0;
            end else if (cnt != 4'd0) begin
              cnt <= '0;
              state <= is_read ? S_RD : S_WR;
              if (is_read) begin
                shift <= rd_data;
                mdio_out <= rd_data[15];
              end
            end
          end
          S_RD: begin
            cnt <= cnt + 4'd1;
            shift <= {shift[14:0], 1'b0};
            mdio_out <= shift[14];
            if (cnt == 4'(pefs_pkg::DATA_BITS - 1)) begin
              mdio_out <= 1'b1;
              mdio_oe_n <= 1'b1;
              state <= S_PRE;
            end
          end
          S_WR: begin
            cnt <= cnt + 4'd1;
            shift <= {shift[14:0], mdio_bit};
            if (cnt == 4'(pefs_pkg::DATA_BITS - 1)) begin
              req.wr <= 1'b1;
              req.wdata <= {shift[14:0], mdio_bit};
              state <= S_PRE;
            end
          end
          default: begin
            state <= S_PRE;
          end
        endcase
      end
    end
  end

  drive_only_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !mdio_oe_n |-> (state == S_TA || state == S_RD) && is_read)
    else $error("data pin driven outside a read");

endmodule : pefs_mgmt_slave

// ===== design/pefs_phy_events.sv
// phy event flags, event mask and special status behind the management interface
`timescale 1ns/1ps

module pefs_phy_events #(
  parameter int ENERGY_TIMEOUT_CYCLES = pefs_pkg::ENERGY_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // management serial pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  // line energy indication from the analog front end
  input wire logic line_energy_raw,
  // conditions from the phy core
  input wire pefs_pkg::pefs_events_t ev,
  // outputs toward the mac
  output logic phy_irq,
  output logic line_energy_present
);

  if (ENERGY_TIMEOUT_CYCLES < 2) begin : g_bad_timeout
    $error("pefs_phy_events: ENERGY_TIMEOUT_CYCLES must be at least 2");
  end

  // pin synchronisers
  logic mdc_s1;
  logic mdc_s2;
  logic mdc_prev;
  logic mdio_s1;
  logic mdio_s2;
  logic energy_s1;
  logic energy_s2;
  logic mdc_rise;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mdc_s1 <= 1'b0;
      mdc_s2 <= 1'b0;
      mdc_prev <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
      energy_s1 <= 1'b0;
      energy_s2 <= 1'b0;
    end else begin
      mdc_s1 <= mdc;
      mdc_s2 <= mdc_s1;
      mdc_prev <= mdc_s2;
      mdio_s1 <= mdio_in;
      mdio_s2 <= mdio_s1;
      energy_s1 <= line_energy_raw;
      energy_s2 <= energy_s1;
    end
  end

  assign mdc_rise = mdc_s2 & ~mdc_prev;

  // management frame handling
  pefs_pkg::pefs_mgmt_req_t req;
  logic [15:0] rd_data;
  logic [4:0] management_phy_address;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      management_phy_address <= pefs_pkg::PHY_ADDR_RST;
    end
  end

  pefs_mgmt_slave u_mgmt (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .mdc_rise(mdc_rise),
    .mdio_bit(mdio_s2),
    .phy_addr(management_phy_address),
    .rd_data(rd_data),
    .req(req),
    .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n)
  );

  // energy presence
  pefs_energy_watch #(
    .TIMEOUT_CYCLES(ENERGY_TIMEOUT_CYCLES)
  ) u_energy (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .energy_seen(energy_s2),
    .line_energy_present(line_energy_present)
  );

  // condition history for edge detection
  logic init_done;
  logic energy_prev;
  logic an_prev;
  logic rfault_prev;
  logic link_prev;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      init_done <= 1'b0;
      energy_prev <= 1'b1;
      an_prev <= 1'b0;
      rfault_prev <= 1'b0;
      link_prev <= 1'b0;
    end else begin
      init_done <= 1'b1;
      energy_prev <= line_energy_present;
      an_prev <= ev.autoneg_done;
      rfault_prev <= ev.remote_fault;
      link_prev <= ev.link_up;
    end
  end

  // event flags, bit 0 reserved and always zero
  logic [7:1] flags;
  logic [7:1] set_vec;
  logic [7:1] hold_vec;
  logic [7:1] next_flags;
  logic clr_flags;

  always_comb begin
    set_vec = '0;
    set_vec[pefs_pkg::BIT_ENERGY] = line_energy_present != energy_prev;
    set_vec[pefs_pkg::BIT_AN_DONE] = init_done & ev.autoneg_done & ~an_prev;
    set_vec[pefs_pkg::BIT_RFAULT] = init_done & ev.remote_fault & ~rfault_prev;
    // first cycle after reset catches the current line state
    set_vec[pefs_pkg::BIT_LINK_DOWN] = init_done ? (~ev.link_up & link_prev)
                                                 : ~ev.link_up;
    set_vec[pefs_pkg::BIT_PARTNER_ACK] = init_done & ev.partner_ack;
    set_vec[pefs_pkg::BIT_PAR_FAULT] = init_done & ev.parallel_fault;
    set_vec[pefs_pkg::BIT_PAGE_RX] = init_done & ev.page_received;
  end

  // remote fault and link down conditions still present survive a read
  always_comb begin
    hold_vec = '0;
    hold_vec[pefs_pkg::BIT_RFAULT] = ev.remote_fault;
    hold_vec[pefs_pkg::BIT_LINK_DOWN] = ~ev.link_up;
  end

  assign clr_flags = req.rd && req.reg_addr == pefs_pkg::REG_FLAGS;

  // a new event in the read cycle wins over the clear
  assign next_flags = clr_flags ? ((flags & hold_vec) | set_vec) : (flags | set_vec);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  // mask register
  logic [7:0] mask;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mask <= pefs_pkg::MASK_RST;
    end else if (req.wr && req.reg_addr == pefs_pkg::REG_MASK) begin
      mask <= req.wdata[7:0];
    end
  end

  // special status
  logic [6:0] status_rsv;
  logic autodone;
  logic [2:0] resolved_speed_duplex;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status_rsv <= pefs_pkg::STATUS_RSV_RST;
    end else if (req.wr && req.reg_addr == pefs_pkg::REG_STATUS) begin
      status_rsv <= req.wdata[11:5];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      autodone <= 1'b0;
      resolved_speed_duplex <= '0;
    end else begin
      autodone <= ev.autoneg_done;
      resolved_speed_duplex <= ev.resolved_speed_duplex;
    end
  end

  // read data, captured with the request
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else if (req.rd) begin
      case (req.reg_addr)
        pefs_pkg::REG_FLAGS: rd_data <= {8'h00, flags, 1'b0};
        pefs_pkg::REG_MASK: rd_data <= {8'h00, mask};
        pefs_pkg::REG_STATUS: begin
          rd_data <= {3'h0, autodone, status_rsv, resolved_speed_duplex, 2'h0};
        end
        default: rd_data <= 16'h0000;
      endcase
    end
  end

  // interrupt request toward the mac
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      phy_irq <= 1'b0;
    end else begin
      phy_irq <= |(flags & mask[7:1]);
    end
  end

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence seq_flag_read;
    req.rd && req.reg_addr == pefs_pkg::REG_FLAGS;
  endsequence

  sequence seq_quiet;
    !clr_flags;
  endsequence

  irq_follows_mask_a: assert property (
    |(flags & mask[7:1]) |=> phy_irq)
    else $error("interrupt request missing for unmasked flag");

  irq_quiet_a: assert property (
    !(|(flags & mask[7:1])) |=> !phy_irq)
    else $error("interrupt request without unmasked flag");

  an_done_flag_a: assert property (
    init_done && $rose(ev.autoneg_done) |=> flags[pefs_pkg::BIT_AN_DONE])
    else $error("autonegotiation completion not flagged");

  rfault_flag_a: assert property (
    init_done && $rose(ev.remote_fault) |=> flags[pefs_pkg::BIT_RFAULT])
    else $error("remote fault not flagged");

  link_down_flag_a: assert property (
    init_done && $fell(ev.link_up) |=> flags[pefs_pkg::BIT_LINK_DOWN])
    else $error("link loss not flagged");

  partner_ack_flag_a: assert property (
    init_done && ev.partner_ack |=> flags[pefs_pkg::BIT_PARTNER_ACK])
    else $error("partner acknowledge not flagged");

  par_fault_flag_a: assert property (
    init_done && ev.parallel_fault |=> flags[pefs_pkg::BIT_PAR_FAULT])
    else $error("parallel detection fault not flagged");

  page_rx_flag_a: assert property (
    init_done && ev.page_received |=> flags[pefs_pkg::BIT_PAGE_RX])
    else $error("page reception not flagged");

  energy_flag_a: assert property (
    line_energy_present != energy_prev |=> flags[pefs_pkg::BIT_ENERGY])
    else $error("energy change not flagged");

  flags_latch_a: assert property (
    seq_quiet |=> (flags & $past(flags)) == $past(flags))
    else $error("flag dropped without a read");

  read_clear_a: assert property (
    seq_flag_read ##0 (set_vec == 7'h00) |=> flags == $past(flags & hold_vec))
    else $error("flag read did not clear as expected");

  read_value_a: assert property (
    seq_flag_read |=> rd_data == {8'h00, $past(flags), 1'b0})
    else $error("flag read returned wrong value");

  mask_write_a: assert property (
    req.wr && req.reg_addr == pefs_pkg::REG_MASK |=> mask == $past(req.wdata[7:0]))
    else $error("mask write not stored");

  status_read_a: assert property (
    req.rd && req.reg_addr == pefs_pkg::REG_STATUS
    |=> rd_data[12] == $past(autodone) && rd_data[4:2] == $past(resolved_speed_duplex))
    else $error("status read wrong");

  status_write_a: assert property (
    req.wr && req.reg_addr == pefs_pkg::REG_STATUS
    |=> status_rsv == $past(req.wdata[11:5]))
    else $error("status reserved field write not stored");

  link_init_a: assert property (
    !init_done && !ev.link_up |=> flags[pefs_pkg::BIT_LINK_DOWN])
    else $error("link down not caught after reset");

endmodule : pefs_phy_events

// ===== design/pefs_pkg.sv
// shared constants and carrier types for the phy event flag and status block
package pefs_pkg;

  // register indices on the management serial interface
  localparam logic [4:0] REG_FLAGS = 5'h1d;
  localparam logic [4:0] REG_MASK = 5'h1e;
  localparam logic [4:0] REG_STATUS = 5'h1f;

  // management address and register values after reset
  localparam logic [4:0] PHY_ADDR_RST = 5'h01;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [6:0] STATUS_RSV_RST = 7'h02;

  // event flag bit positions
  localparam int BIT_ENERGY = 7;
  localparam int BIT_AN_DONE = 6;
  localparam int BIT_RFAULT = 5;
  localparam int BIT_LINK_DOWN = 4;
  localparam int BIT_PARTNER_ACK = 3;
  localparam int BIT_PAR_FAULT = 2;
  localparam int BIT_PAGE_RX = 1;

  // special status field positions
  localparam int STAT_AUTODONE_BIT = 12;
  localparam int STAT_RSV_LSB = 5;
  localparam int STAT_SPEED_LSB = 2;

  // resolved speed and duplex encodings
  localparam logic [2:0] SPD_10_HALF = 3'h1;
  localparam logic [2:0] SPD_10_FULL = 3'h5;
  localparam logic [2:0] SPD_100_HALF = 3'h2;
  localparam logic [2:0] SPD_100_FULL = 3'h6;

  // management frame fields
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam int PREAMBLE_ONES = 32;
  localparam int HDR_BITS = 12;
  localparam int DATA_BITS = 16;

  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int ENERGY_TIMEOUT_MS = 256;
  localparam int ENERGY_TIMEOUT_CYC = ENERGY_TIMEOUT_MS * (CLK_HZ / 1000);

  // condition inputs from the phy core, same clock
  typedef struct packed {
    logic autoneg_done;
    logic remote_fault;
    logic link_up;
    logic partner_ack;
    logic parallel_fault;
    logic page_received;
    logic [2:0] resolved_speed_duplex;
  } pefs_events_t;

  // register request decoded from a management frame
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] reg_addr;
    logic [15:0] wdata;
  } pefs_mgmt_req_t;

endpackage : pefs_pkg

// ===== tb/pefs_mac_model.sv
// management station model that clocks frames over mdc and the shared data pin
`timescale 1ns/1ps
module pefs_mac_model (
  // clock
  input wire logic clk_sys,
  // pin as resolved by the bench, and the block's drive enable
  input wire logic mdio_pin,
  input wire logic mdio_oe_n,
  // station drive
  output logic mdc,
  output logic mac_oe,
  output logic mac_bit
);
  logic drove;

  initial begin
    mdc = 1'b0;
    mac_oe = 1'b0;
    mac_bit = 1'b1;
    drove = 1'b0;
  end

  // one mdc period of ten clocks (2 MHz); the pin is sampled just before the rise
  task automatic clk_bit(input logic drv, input logic b, output logic s);
    @(negedge clk_sys);
    mdc = 1'b0;
    mac_oe = drv;
    mac_bit = b;
    repeat (4) @(negedge clk_sys);
    s = mdio_pin;
    if (mdio_oe_n === 1'b0) begin
      drove = 1'b1;
    end
    mdc = 1'b1;
    repeat (5) @(negedge clk_sys);
  endtask : clk_bit

  // full frame; on a read the station releases the pin from the turnaround on
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd, output logic ta);
    logic [45:0] hdr;
    logic s;
    logic rdop;
    hdr = {32'hffffffff, 2'b01, op, pa, ra};
    rdop = (op == pefs_pkg::OP_READ);
    drove = 1'b0;
    for (int i = 45; i >= 0; i--) begin
      clk_bit(1'b1, hdr[i], s);
    end
    clk_bit(!rdop, 1'b1, s);
    clk_bit(!rdop, 1'b0, ta);
    for (int i = 15; i >= 0; i--) begin
      clk_bit(!rdop, wd[i], rd[i]);
    end
    clk_bit(1'b0, 1'b1, s);
  endtask : frame
endmodule : pefs_mac_model

// ===== tb/pefs_phy_events_tb.sv
// self-checking bench for the phy event flags, mask and status block
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; $display("[FAIL] t=%0t got %h exp %h", $time, (got), (exp)); end end
module pefs_phy_events_tb;
  localparam int TMO = 20;
  logic clk_sys;
  logic sys_rst;
  logic mdc;
  logic mac_oe;
  logic mac_bit;
  wire logic mdio_in;
  logic mdio_out;
  logic mdio_oe_n;
  logic line_energy_raw;
  pefs_pkg::pefs_events_t ev;
  logic phy_irq;
  logic line_energy_present;
  int errors;
  int tests_run;

  // pull-up on the data pin when nobody drives it
  assign mdio_in = !mdio_oe_n ? mdio_out : (mac_oe ? mac_bit : 1'b1);

  pefs_phy_events #(.ENERGY_TIMEOUT_CYCLES(TMO)) dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .line_energy_raw(line_energy_raw),
    .ev(ev), .phy_irq(phy_irq), .line_energy_present(line_energy_present)
  );

  pefs_mac_model mac_u (
    .clk_sys(clk_sys), .mdio_pin(mdio_in), .mdio_oe_n(mdio_oe_n),
    .mdc(mdc), .mac_oe(mac_oe), .mac_bit(mac_bit)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic logic [15:0] exp_stat(input logic done, input logic [2:0] code);
    return {3'h0, done, 7'h02, code, 2'h0};
  endfunction : exp_stat

  task automatic test_done();
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  task automatic rd_reg(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] d;
    logic ta;
    mac_u.frame(pefs_pkg::OP_READ, pefs_pkg::PHY_ADDR_RST, ra, 16'h0000, d, ta);
    `CHK(ta, 1'b0)
    `CHK(d, exp)
    `CHK(mdio_oe_n, 1'b1)
  endtask : rd_reg

  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] d;
    logic ta;
    mac_u.frame(pefs_pkg::OP_WRITE, pefs_pkg::PHY_ADDR_RST, ra, wd, d, ta);
  endtask : wr_reg

  task automatic t_reset();
    `CHK(phy_irq, 1'b0)
    rd_reg(pefs_pkg::REG_MASK, 16'h0000);
    rd_reg(pefs_pkg::REG_STATUS, exp_stat(1'b0, 3'h6));
    rd_reg(pefs_pkg::REG_FLAGS, 16'h0010);
    rd_reg(pefs_pkg::REG_FLAGS, 16'h0000);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_events();
    for (int i = 1; i <= 6; i++) begin
      @(negedge clk_sys);
      case (i)
        1: ev.page_received = 1'b1;
        2: ev.parallel_fault = 1'b1;
        3: ev.partner_ack = 1'b1;
        4: ev.link_up = 1'b0;
        5: ev.remote_fault = 1'b1;
        default: ev.autoneg_done = 1'b1;
      endcase
      @(negedge clk_sys);
      ev.page_received = 1'b0;
      ev.parallel_fault = 1'b0;
      ev.partner_ack = 1'b0;
      ev.link_up = 1'b1;
      ev.remote_fault = 1'b0;
      rd_reg(pefs_pkg::REG_FLAGS, 16'h0001 << i);
      rd_reg(pefs_pkg::REG_FLAGS, 16'h0000);
    end
    ev.remote_fault = 1'b1;
    rd_reg(pefs_pkg::REG_FLAGS, 16'h0020);
    rd_reg(pefs_pkg::REG_FLAGS, 16'h0020);
    ev.remote_fault = 1'b0;
    rd_reg(pefs_pkg::REG_FLAGS, 16'h0020);
    rd_reg(pefs_pkg::REG_FLAGS, 16'h0000);
    line_energy_raw = 1'b0;
    repeat (10) @(negedge clk_sys);
    `CHK(line_energy_present, 1'b1)
    repeat (TMO + 5) @(negedge clk_sys);
    `CHK(line_energy_present, 1'b0)
    line_energy_raw = 1'b1;
    repeat (10) @(negedge clk_sys);
    `CHK(line_energy_present, 1'b1)
    rd_reg(pefs_pkg::REG_FLAGS, 16'h0080);
    rd_reg(pefs_pkg::REG_FLAGS, 16'h0000);
    $display("t_events done");
  endtask : t_events

  task automatic t_mask();
    wr_reg(pefs_pkg::REG_MASK, 16'h0008);
    rd_reg(pefs_pkg::REG_MASK, 16'h0008);
    @(negedge clk_sys);
    ev.page_received = 1'b1;
    @(negedge clk_sys);
    ev.page_received = 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK(phy_irq, 1'b0)
    ev.partner_ack = 1'b1;
    @(negedge clk_sys);
    ev.partner_ack = 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK(phy_irq, 1'b1)
    rd_reg(pefs_pkg::REG_FLAGS, 16'h000a);
    `CHK(phy_irq, 1'b0)
    $display("t_mask done");
  endtask : t_mask

  task automatic t_status();
    logic [2:0] codes [4];
    codes = '{3'h1, 3'h5, 3'h2, 3'h6};
    foreach (codes[i]) begin
      @(negedge clk_sys);
      ev.resolved_speed_duplex = codes[i];
      rd_reg(pefs_pkg::REG_STATUS, exp_stat(1'b1, codes[i]));
    end
    wr_reg(pefs_pkg::REG_STATUS, 16'h0040);
    ev.autoneg_done = 1'b0;
    rd_reg(pefs_pkg::REG_STATUS, exp_stat(1'b0, 3'h6));
    $display("t_status done");
  endtask : t_status

  task automatic t_refuse();
    logic [15:0] d;
    logic ta;
    mac_u.frame(pefs_pkg::OP_READ, 5'h02, pefs_pkg::REG_FLAGS, 16'h0000, d, ta);
    `CHK(mac_u.drove, 1'b0)
    `CHK(ta, 1'b1)
    wr_reg(pefs_pkg::REG_FLAGS, 16'h00fe);
    rd_reg(pefs_pkg::REG_FLAGS, 16'h0000);
    rd_reg(5'h00, 16'h0000);
    $display("t_refuse done");
  endtask : t_refuse

  initial begin
    errors = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    line_energy_raw = 1'b1;
    ev = '0;
    ev.resolved_speed_duplex = 3'h6;
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    ev.link_up = 1'b1;
    t_reset();
    t_events();
    t_mask();
    t_status();
    t_refuse();
    test_done();
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    errors++;
    test_done();
  end
endmodule : pefs_phy_events_tb
